// *** pkg/clock_reset_consts.svh ***
// Offsets, field positions, reset values and timing counts of the clock and reset generator
`ifndef CLOCK_RESET_CONSTS_SVH
`define CLOCK_RESET_CONSTS_SVH

// ***********************************************
// Register offsets (word indexes from the base)
// ***********************************************
`define OFS_PLL_MULTIPLIER        4'h0
`define OFS_PLL_REFERENCE_DIVIDER 4'h1
`define OFS_FACTORY_TEST_FLAGS    4'h2
`define OFS_CLOCK_STATUS_FLAGS    4'h3
`define OFS_CLOCK_INTERRUPT_EN    4'h4
`define OFS_CLOCK_SOURCE_SELECT   4'h5
`define OFS_PLL_CONTROL           4'h6
`define OFS_PERIODIC_TICK_CONTROL 4'h7
`define OFS_WATCHDOG_CONTROL      4'h8
`define OFS_FACTORY_FORCE_BYPASS  4'h9
`define OFS_FACTORY_TEST_CONTROL  4'ha
`define OFS_WATCHDOG_SERVICE      4'hb

// ***********************************************
// Writable bit masks
// ***********************************************
`define MASK_MULTIPLIER    8'h3f
`define MASK_REF_DIVIDER   8'h0f
`define MASK_INT_ENABLES   8'h92
`define MASK_PLL_CONTROL   8'hf7
`define MASK_TICK_CONTROL  8'h7f
`define MASK_WDOG_CONTROL  8'hc7

// ***********************************************
// Field positions
// ***********************************************
`define BIT_PLL_CLOCK_SELECT   7
`define BIT_PSEUDO_STOP_SELECT 6
`define BIT_SYS_WAIT_GATE      5
`define BIT_CORE_WAIT_GATE     2
`define BIT_TICK_WAIT_GATE     1
`define BIT_WDOG_WAIT_GATE     0
`define BIT_CLOCK_MONITOR_EN   7
`define BIT_PLL_ON             6
`define BIT_SELF_CLOCK_EN      0
`define BIT_TICK_STOP_EN       7
`define BIT_WDOG_STOP_EN       6
`define BIT_FLAG_LOCK_CHANGE   4
`define BIT_FLAG_LOCK          3
`define BIT_FLAG_TRACK         2
`define BIT_FLAG_SCM_CHANGE    1
`define BIT_FLAG_SCM           0

// ***********************************************
// Reset values
// ***********************************************
`define RST_PLL_CONTROL   8'hf1
`define RST_ZERO          8'h00

// ***********************************************
// Timing
// ***********************************************
`define CLOCK_PERIOD_NS      25
`define RESET_PULSE_NS       1000
`define RESET_PULSE_CYCLES   ((`RESET_PULSE_NS) / (`CLOCK_PERIOD_NS))
`define QUALITY_CHECK_NS     50000
`define QUALITY_CHECK_CYCLES ((`QUALITY_CHECK_NS) / (`CLOCK_PERIOD_NS))

`endif

// *** pkg/clock_reset_pkg.sv ***
// Types of the clock and reset generator
package clock_reset_pkg;

  typedef enum logic [2:0] {
    mode_run,
    mode_wait,
    mode_full_stop,
    mode_pseudo_stop,
    mode_self_clock
  } clock_mode_type;

  typedef struct packed {
    logic [3:0] address;
    logic [7:0] write_data;
    logic       write_strobe;
    logic       read_strobe;
  } reg_request_type;

  typedef struct packed {
    logic wait_request;
    logic stop_request;
    logic clock_lost;
    logic clock_good;
    logic pll_locked;
    logic pll_tracking;
    logic internal_reset;
  } plant_status_type;

  typedef struct packed {
    logic       oscillator_enable;
    logic       pll_enable;
    logic       system_clock_enable;
    logic       core_clock_enable;
    logic       bus_from_pll;
    logic       pll_at_minimum;
    logic       quality_check_active;
    logic       watchdog_run;
    logic       tick_run;
    logic [7:0] pll_loop_multiplier;
    logic [4:0] pll_reference_division;
  } clock_control_type;

endpackage : clock_reset_pkg

// *** rtl/clock_reset_generator_config.sv ***
// Register map and mode sequencing of the clock and reset generator
`include "clock_reset_consts.svh"

// What this block does
// R1 - Tick and watchdog run only after software loads a nonzero rate value.
// R2 - Wait mode gates system and core clocks per clock select bits.
// R3 - Stop enters full stop if pseudo-stop select is 0, else pseudo-stop.
// R4 - Full stop disables oscillator, halts clocks, freezes watchdog and tick.
// R5 - Pseudo-stop keeps oscillator; watchdog and tick run only if enabled.
// R6 - Self-clock entered when monitor and self-clock enabled and clock lost.
// R7 - Entering self-clock mode starts an oscillator clock quality check.
// R8 - Self-clock mode is left only after the quality check passes.
// R9 - Reset pin low resets asynchronously; device drives it low on internal reset. Here only arst_n resets; reset_pin_in_n is unused.
// R10 - PLL output equals reference times two times multiplier plus one.
// R11 - PLL output never falls below the minimum self-clock frequency.
// R12 - With PLL selected the bus clock is PLL output divided by two.
// R13 - Reference divider divides oscillator clock by divider value plus one.
// R14 - Multiplier writes ignored while PLL clock select is set.
// R15 - Reference divider writes ignored while PLL clock select is set.
// R16 - Accepted multiplier or divider write reinitializes lock and track bits.
// R17 - Factory test flags read zero and ignore writes.
// R18 - Each register answers at base plus its own offset.
// R19 - Self-clock mode derives clocks from the PLL at minimum frequency.
// R20 - Unimplemented and reserved bits read zero and ignore writes.
module clock_reset_generator_config
  import clock_reset_pkg::*;
(
  input  wire logic                              clock,
  input  wire logic                              arst_n,
  input  wire clock_reset_pkg::reg_request_type  request,
  output logic [7:0]                             read_data,
  input  wire clock_reset_pkg::plant_status_type plant,
  output clock_reset_pkg::clock_control_type     control,
  output clock_reset_pkg::clock_mode_type        mode,
  input  wire logic                              reset_pin_in_n,
  output logic                                   reset_pin_out_n,
  output logic                                   reset_pin_oe
);
  import clock_reset_pkg::*;

  // ***********************************************
  // State
  // ***********************************************
  typedef struct packed {
    logic [7:0]        multiplier_value;
    logic [7:0]        reference_divider_value;
    logic [7:0]        status_flags;
    logic [7:0]        interrupt_enables;
    logic [7:0]        clock_source_select;
    logic [7:0]        pll_control;
    logic [7:0]        periodic_tick_rate;
    logic [7:0]        watchdog_rate;
    logic [7:0]        read_data;
    clock_mode_type    mode;
    logic [15:0]       quality_count;
    logic [7:0]        reset_count;
    logic              lock_hold;
    clock_control_type control;
    logic              reset_pin_oe;
  } state_type;

  state_type state;
  state_type next_state;

  logic       write_multiplier;
  logic       write_divider;
  logic       pll_selected;
  logic [7:0] read_mux;

  always_comb begin
    pll_selected     = state.clock_source_select[`BIT_PLL_CLOCK_SELECT];
    write_multiplier = request.write_strobe && request.address == `OFS_PLL_MULTIPLIER && !pll_selected; // [R14] [R18]
    write_divider    = request.write_strobe && request.address == `OFS_PLL_REFERENCE_DIVIDER && !pll_selected; // [R15]
  end

  // ***********************************************
  // Read decode
  // ***********************************************
  always_comb begin
    case (request.address) // [R18]
      `OFS_PLL_MULTIPLIER:        read_mux = state.multiplier_value;
      `OFS_PLL_REFERENCE_DIVIDER: read_mux = state.reference_divider_value;
      `OFS_CLOCK_STATUS_FLAGS:    read_mux = state.status_flags;
      `OFS_CLOCK_INTERRUPT_EN:    read_mux = state.interrupt_enables;
      `OFS_CLOCK_SOURCE_SELECT:   read_mux = state.clock_source_select;
      `OFS_PLL_CONTROL:           read_mux = state.pll_control;
      `OFS_PERIODIC_TICK_CONTROL: read_mux = state.periodic_tick_rate;
      `OFS_WATCHDOG_CONTROL:      read_mux = state.watchdog_rate;
      // Factory test, service and unmapped offsets read zero
      default:                    read_mux = `RST_ZERO; // [R17] [R20]
    endcase
  end

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    logic tick_allowed;
    logic wdog_allowed;
    logic lock_now;
    logic track_now;
    tick_allowed = 1'b0;
    wdog_allowed = 1'b0;
    lock_now     = 1'b0;
    track_now    = 1'b0;
    next_state   = state;

    // Register writes; masks keep reserved bits at zero
    if (write_multiplier) begin
      next_state.multiplier_value = request.write_data & `MASK_MULTIPLIER; // [R14] [R20]
    end
    if (write_divider) begin
      next_state.reference_divider_value = request.write_data & `MASK_REF_DIVIDER; // [R15] [R20]
    end
    if (request.write_strobe) begin
      case (request.address)
        `OFS_CLOCK_INTERRUPT_EN:    next_state.interrupt_enables  = request.write_data & `MASK_INT_ENABLES; // [R20]
        `OFS_CLOCK_SOURCE_SELECT:   next_state.clock_source_select = request.write_data;
        `OFS_PLL_CONTROL:           next_state.pll_control        = request.write_data & `MASK_PLL_CONTROL; // [R20]
        `OFS_PERIODIC_TICK_CONTROL: next_state.periodic_tick_rate = request.write_data & `MASK_TICK_CONTROL;
        `OFS_WATCHDOG_CONTROL:      next_state.watchdog_rate      = request.write_data & `MASK_WDOG_CONTROL;
        // Factory test registers swallow writes
        default:                    next_state.reset_pin_oe       = state.reset_pin_oe; // [R17]
      endcase
    end
    next_state.read_data = request.read_strobe ? read_mux : `RST_ZERO;

    // Change flags clear on writing one; a new change in the same cycle wins
    if (request.write_strobe && request.address == `OFS_CLOCK_STATUS_FLAGS) begin
      next_state.status_flags[7:4] = state.status_flags[7:4] & ~request.write_data[7:4] & 4'hf;
      next_state.status_flags[`BIT_FLAG_SCM_CHANGE] =
        state.status_flags[`BIT_FLAG_SCM_CHANGE] & ~request.write_data[`BIT_FLAG_SCM_CHANGE];
    end

    // ***********************************************
    // Mode sequencing
    // ***********************************************
    case (state.mode)
      mode_run, mode_wait: begin
        if (state.pll_control[`BIT_CLOCK_MONITOR_EN] && state.pll_control[`BIT_SELF_CLOCK_EN]
            && plant.clock_lost) begin
          next_state.mode          = mode_self_clock; // [R6]
          next_state.quality_count = 16'h0000; // [R7]
        end else if (plant.stop_request) begin
          next_state.mode = state.clock_source_select[`BIT_PSEUDO_STOP_SELECT]
                            ? mode_pseudo_stop : mode_full_stop; // [R3]
        end else if (plant.wait_request) begin
          next_state.mode = mode_wait;
        end else begin
          next_state.mode = mode_run;
        end
      end
      mode_full_stop, mode_pseudo_stop: begin
        if (!plant.stop_request) begin
          next_state.mode = mode_run;
        end
      end
      mode_self_clock: begin
        // Leave only once the oscillator has looked good for the whole check window
        if (!plant.clock_good) begin
          next_state.quality_count = 16'h0000; // [R8]
        end else if (state.quality_count >= 16'(`QUALITY_CHECK_CYCLES)) begin
          next_state.mode = mode_run; // [R8]
        end else begin
          next_state.quality_count = state.quality_count + 16'h0001; // [R7]
        end
      end
      default: next_state.mode = mode_run;
    endcase

    // Self-clock change flag, set wins over clear
    if ((next_state.mode == mode_self_clock) != (state.mode == mode_self_clock)) begin
      next_state.status_flags[`BIT_FLAG_SCM_CHANGE] = 1'b1;
    end
    next_state.status_flags[`BIT_FLAG_SCM] = next_state.mode == mode_self_clock;

    // Lock and track cleared by an accepted write and in self-clock mode
    next_state.lock_hold = write_multiplier || write_divider; // [R16]
    if (!(write_multiplier || write_divider || state.lock_hold) && state.mode != mode_self_clock) begin
      lock_now  = plant.pll_locked;
      track_now = plant.pll_tracking;
    end
    if (lock_now != state.status_flags[`BIT_FLAG_LOCK]) begin
      next_state.status_flags[`BIT_FLAG_LOCK_CHANGE] = 1'b1;
    end
    next_state.status_flags[`BIT_FLAG_LOCK]  = lock_now; // [R16]
    next_state.status_flags[`BIT_FLAG_TRACK] = track_now; // [R16]

    // ***********************************************
    // Clock controls
    // ***********************************************
    // Tick and watchdog are dead until software gives them a rate
    tick_allowed = state.periodic_tick_rate[6:0] != 7'h00; // [R1]
    wdog_allowed = state.watchdog_rate[2:0] != 3'h0; // [R1]

    next_state.control.oscillator_enable   = next_state.mode != mode_full_stop; // [R4] [R5]
    next_state.control.pll_enable          = state.pll_control[`BIT_PLL_ON] || next_state.mode == mode_self_clock;
    next_state.control.pll_at_minimum      = next_state.mode == mode_self_clock; // [R11] [R19]
    next_state.control.quality_check_active = next_state.mode == mode_self_clock; // [R7]
    next_state.control.bus_from_pll        = pll_selected || next_state.mode == mode_self_clock; // [R12] [R19]
    // Multiplier and divider are handed on as the factors the PLL must apply
    // Eight bits: the top multiplier value gives a factor of 128
    next_state.control.pll_loop_multiplier    = {1'b0, state.multiplier_value[5:0], 1'b0} + 8'h02; // [R10]
    next_state.control.pll_reference_division = {1'b0, state.reference_divider_value[3:0]} + 5'h01; // [R13]

    case (next_state.mode)
      mode_wait: begin
        next_state.control.system_clock_enable = !state.clock_source_select[`BIT_SYS_WAIT_GATE]; // [R2]
        next_state.control.core_clock_enable   = !state.clock_source_select[`BIT_CORE_WAIT_GATE]; // [R2]
        next_state.control.tick_run = tick_allowed && !state.clock_source_select[`BIT_TICK_WAIT_GATE];
        next_state.control.watchdog_run = wdog_allowed && !state.clock_source_select[`BIT_WDOG_WAIT_GATE];
      end
      mode_full_stop: begin
        next_state.control.system_clock_enable = 1'b0; // [R4]
        next_state.control.core_clock_enable   = 1'b0; // [R4]
        next_state.control.tick_run            = 1'b0; // [R4]
        next_state.control.watchdog_run        = 1'b0; // [R4]
      end
      mode_pseudo_stop: begin
        next_state.control.system_clock_enable = 1'b0; // [R5]
        next_state.control.core_clock_enable   = 1'b0; // [R5]
        next_state.control.tick_run     = tick_allowed && state.pll_control[`BIT_TICK_STOP_EN]; // [R5]
        next_state.control.watchdog_run = wdog_allowed && state.pll_control[`BIT_WDOG_STOP_EN]; // [R5]
      end
      default: begin
        next_state.control.system_clock_enable = 1'b1;
        next_state.control.core_clock_enable   = 1'b1;
        next_state.control.tick_run            = tick_allowed; // [R1]
        next_state.control.watchdog_run        = wdog_allowed; // [R1]
      end
    endcase

    // ***********************************************
    // Reset pin drive
    // ***********************************************
    // A pulse stretcher so a one-cycle internal reset is seen off chip
    if (plant.internal_reset) begin
      next_state.reset_count  = 8'(`RESET_PULSE_CYCLES); // [R9]
      next_state.reset_pin_oe = 1'b1; // [R9]
    end else if (state.reset_count != 8'h00) begin
      next_state.reset_count  = state.reset_count - 8'h01;
      next_state.reset_pin_oe = 1'b1;
    end else begin
      next_state.reset_pin_oe = 1'b0;
    end
  end

  // ***********************************************
  // Registers
  // ***********************************************
  // arst_n is the reset input, reset_pin_in_n is not used: a low arst_n loads every reset value at once
  always_ff @(posedge clock or negedge arst_n) begin // [R9]
    if (!arst_n) begin
      state                     <= '0;
      state.pll_control         <= `RST_PLL_CONTROL;
      state.mode                <= mode_run;
      state.control.oscillator_enable   <= 1'b1;
      state.control.pll_enable          <= 1'b1;
      state.control.system_clock_enable <= 1'b1;
      state.control.core_clock_enable   <= 1'b1;
      state.control.pll_loop_multiplier    <= 8'h02;
      state.control.pll_reference_division <= 5'h01;
    end else begin
      state <= next_state;
    end
  end

  assign read_data       = state.read_data;
  assign control         = state.control;
  assign mode            = state.mode;
  assign reset_pin_out_n = 1'b0; // [R9]
  assign reset_pin_oe    = state.reset_pin_oe; // [R9]

endmodule : clock_reset_generator_config

// *** bench/clock_reset_checker.sv ***
// Port-level assertions of the clock and reset generator
`include "clock_reset_consts.svh"
module clock_reset_checker
  import clock_reset_pkg::*;
(
  input wire logic                              clock,
  input wire logic                              arst_n,
  input wire clock_reset_pkg::reg_request_type  request,
  input wire logic [7:0]                        read_data,
  input wire clock_reset_pkg::plant_status_type plant,
  input wire clock_reset_pkg::clock_control_type control,
  input wire clock_reset_pkg::clock_mode_type   mode,
  input wire logic                              reset_pin_in_n,
  input wire logic                              reset_pin_out_n,
  input wire logic                              reset_pin_oe
);
  import clock_reset_pkg::*;
  // ************************************************
  // Shadow bits, taken from the bus, not the design
  // ************************************************
  logic pll_sel;
  logic pseudo_stop_select;
  logic clock_monitor_enable;
  logic self_clock_enable;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pll_sel <= 1'b0;
      pseudo_stop_select    <= 1'b0;
      clock_monitor_enable     <= 1'b1;
      self_clock_enable    <= 1'b1;
    end else if (request.write_strobe && request.address == `OFS_CLOCK_SOURCE_SELECT) begin
      pll_sel <= request.write_data[`BIT_PLL_CLOCK_SELECT];
      pseudo_stop_select    <= request.write_data[`BIT_PSEUDO_STOP_SELECT];
    end else if (request.write_strobe && request.address == `OFS_PLL_CONTROL) begin
      clock_monitor_enable     <= request.write_data[`BIT_CLOCK_MONITOR_EN];
      self_clock_enable    <= request.write_data[`BIT_SELF_CLOCK_EN];
    end
  end
  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Eight bits so that a wrap of the top value is caught
  mult_value_a: assert property (request.write_strobe && request.address == `OFS_PLL_MULTIPLIER && !pll_sel
      |-> ##2 control.pll_loop_multiplier == ((($past(request.write_data, 2) & 8'h3f) + 8'h01) << 1))
    else $error("multiplier output does not follow written value");
  div_value_a: assert property (request.write_strobe && request.address == `OFS_PLL_REFERENCE_DIVIDER && !pll_sel
      |-> ##2 {3'b000, control.pll_reference_division} == ($past(request.write_data, 2) & 8'h0f) + 8'h01)
    else $error("division output does not follow written value");
  mult_lock_a: assert property (request.write_strobe && request.address == `OFS_PLL_MULTIPLIER && pll_sel |=> $stable(control.pll_loop_multiplier)[*2])
    else $error("multiplier changed while locked");
  div_lock_a: assert property (request.write_strobe && request.address == `OFS_PLL_REFERENCE_DIVIDER && pll_sel |=> $stable(control.pll_reference_division)[*2])
    else $error("divider changed while locked");
  test_flags_a: assert property (request.read_strobe && request.address == `OFS_FACTORY_TEST_FLAGS |=> read_data == 8'h00)
    else $error("factory test flags not zero");
  pin_drive_a: assert property (plant.internal_reset |=> reset_pin_oe && reset_pin_out_n == 1'b0)
    else $error("reset pin not driven low on internal reset");
  stop_entry_a: assert property (mode == mode_run && plant.stop_request && !plant.clock_lost |=> mode == (pseudo_stop_select ? mode_pseudo_stop : mode_full_stop))
    else $error("wrong stop mode entered");
  full_stop_a: assert property ($past(mode) == mode_full_stop && mode == mode_full_stop |-> !control.oscillator_enable && !control.system_clock_enable && !control.core_clock_enable && !control.watchdog_run && !control.tick_run)
    else $error("clocks still running in full stop");
  self_entry_a: assert property (mode == mode_run && clock_monitor_enable && self_clock_enable && plant.clock_lost |=> mode == mode_self_clock)
    else $error("self-clock mode not entered");
  self_hold_a: assert property (mode == mode_self_clock && !plant.clock_good |=> mode == mode_self_clock)
    else $error("self-clock mode left without good clock");
  self_check_a: assert property ($past(mode) == mode_self_clock && mode == mode_self_clock |-> control.quality_check_active && control.pll_at_minimum)
    else $error("quality check or minimum clock missing in self-clock");
  cover property (mode == mode_full_stop);
  cover property (mode == mode_pseudo_stop);
  cover property (mode == mode_self_clock ##1 mode == mode_run);
  cover property ($rose(reset_pin_oe));
endmodule : clock_reset_checker

bind clock_reset_generator_config clock_reset_checker chk_u (.clock(clock), .arst_n(arst_n), .request(request),
  .read_data(read_data), .plant(plant), .control(control), .mode(mode), .reset_pin_in_n(reset_pin_in_n),
  .reset_pin_out_n(reset_pin_out_n), .reset_pin_oe(reset_pin_oe));

// *** bench/tb.sv ***
// Self-checking testbench of the clock and reset generator
`include "clock_reset_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_reset_pkg::*;
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  reg_request_type   request = '0;
  plant_status_type  plant = '0;
  logic [7:0]        read_data;
  clock_control_type control;
  clock_mode_type    mode;
  logic              reset_pin_out_n;
  logic              reset_pin_oe;
  wire               reset_pin_n = reset_pin_oe ? reset_pin_out_n : 1'b1;
  int                num_errors = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                regs [16];
  int                i;
  int                a;
  logic [7:0]        d;
  always #12.5 clock = ~clock;
  clock_reset_generator_config dut_u (.clock(clock), .arst_n(arst_n), .request(request), .read_data(read_data),
    .plant(plant), .control(control), .mode(mode), .reset_pin_in_n(reset_pin_n), .reset_pin_out_n(reset_pin_out_n),
    .reset_pin_oe(reset_pin_oe));
  // ************************************************
  // Bus tasks and reference model
  // ************************************************
  function automatic logic [7:0] mask(logic [3:0] adr);
    case (adr)
      4'h0: return `MASK_MULTIPLIER;
      4'h1: return `MASK_REF_DIVIDER;
      4'h4: return `MASK_INT_ENABLES;
      4'h5: return 8'hff;
      4'h6: return `MASK_PLL_CONTROL;
      4'h7: return `MASK_TICK_CONTROL;
      4'h8: return `MASK_WDOG_CONTROL;
      default: return 8'h00;
    endcase
  endfunction : mask
  task automatic model_reset();
    for (int k = 0; k < 16; k++) regs[k] = 0;
    regs[6] = `RST_PLL_CONTROL;
  endtask : model_reset
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(logic [3:0] adr, logic [7:0] dat);
    @(posedge clock);
    request.address <= adr;
    request.write_data <= dat;
    request.write_strobe <= 1'b1;
    @(posedge clock);
    request.write_strobe <= 1'b0;
    if (!(adr < 4'h2 && regs[5][7])) regs[adr] = dat & mask(adr);
  endtask : wr
  task automatic rd(logic [3:0] adr, logic [7:0] m, string what);
    @(posedge clock);
    request.address <= adr;
    request.read_strobe <= 1'b1;
    @(posedge clock);
    request.read_strobe <= 1'b0;
    #1;
    check(what, regs[adr][7:0] & m, read_data & m);
  endtask : rd
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // Generous ceiling: the quality check alone takes two thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ************************************************
  // Tests
  // ************************************************
  initial begin
    model_reset();
    void'($urandom(44208));
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    for (i = 0; i < 16; i++) rd(i[3:0], 8'hff, "reset value");
    check("idle rates", 8'h00, {6'h0, control.tick_run, control.watchdog_run});
    $display("test reset done");
    for (i = 0; i < 80; i++) begin
      a = $urandom % 16;
      if (a == 3) a = 4;
      plant.pll_locked <= 1'($urandom);
      wr(a[3:0], 8'($urandom));
      cyc(2);
      check("multiplier", 8'(2 * (regs[0] + 1)), control.pll_loop_multiplier);
      check("bus select", 8'(regs[5][7]), {7'h0, control.bus_from_pll});
      check("division", 8'(regs[1] + 1), {3'h0, control.pll_reference_division});
    end
    for (i = 0; i < 16; i++) if (i != 3) rd(i[3:0], 8'hff, "readback");
    $display("test random access done");
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h81);
    wr(4'h7, 8'h05);
    wr(4'h8, 8'h01);
    cyc(3);
    check("run rates", 8'h03, {6'h0, control.tick_run, control.watchdog_run});
    plant.pll_locked   <= 1'b1;
    plant.pll_tracking <= 1'b1;
    cyc(2);
    regs[3] = 8'h0c;
    rd(4'h3, 8'h0c, "lock before write");
    wr(4'h0, 8'h3f);
    regs[3] = 8'h00;
    rd(4'h3, 8'h0c, "lock after write");
    for (i = 0; i < 2; i++) begin
      d = i ? 8'h03 : 8'h24;
      wr(4'h5, d);
      plant.wait_request <= 1'b1;
      cyc(3);
      check("wait mode", 8'(mode_wait), 8'(mode));
      check("wait gating", {4'h0, ~d[5], ~d[2], ~d[1], ~d[0]}, {4'h0, control.system_clock_enable,
        control.core_clock_enable, control.tick_run, control.watchdog_run});
      plant.wait_request <= 1'b0;
      cyc(3);
    end
    $display("test wait done");
    for (i = 0; i < 2; i++) begin
      wr(4'h5, i ? 8'h40 : 8'h00);
      plant.stop_request <= 1'b1;
      cyc(3);
      check("stop mode", i ? 8'(mode_pseudo_stop) : 8'(mode_full_stop), 8'(mode));
      check("stop clocks", i ? 8'h06 : 8'h00, {5'h0, control.oscillator_enable, control.tick_run,
        control.watchdog_run});
      plant.stop_request <= 1'b0;
      cyc(3);
      check("stop exit", 8'(mode_run), 8'(mode));
    end
    $display("test stop done");
    plant.clock_lost <= 1'b1;
    cyc(3);
    check("self clock", 8'(mode_self_clock), 8'(mode));
    check("self clock controls", 8'h0f, {4'h0, control.quality_check_active, control.pll_at_minimum,
      control.bus_from_pll, control.pll_enable});
    regs[3] = 8'h03;
    rd(4'h3, 8'h0f, "self clock status");
    plant.clock_lost <= 1'b0;
    plant.clock_good <= 1'b1;
    cyc(`QUALITY_CHECK_CYCLES - 10);
    check("self clock hold", 8'(mode_self_clock), 8'(mode));
    for (i = 0; i < 30 && mode === mode_self_clock; i++) cyc(1);
    check("self clock exit", 8'(mode_run), 8'(mode));
    $display("test self clock done");
    @(posedge clock);
    plant.internal_reset <= 1'b1;
    @(posedge clock);
    plant.internal_reset <= 1'b0;
    cyc(1);
    check("reset pin low", 8'h00, {7'h0, reset_pin_n});
    cyc(`RESET_PULSE_CYCLES - 5);
    check("reset pin held", 8'h00, {7'h0, reset_pin_n});
    cyc(10);
    check("reset pin free", 8'h01, {7'h0, reset_pin_n});
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    model_reset();
    for (i = 5; i < 9; i++) rd(i[3:0], 8'hff, "second reset");
    $display("test reset pin done");
    tally_and_finish();
  end
endmodule : tb
